// >>> fboc_pkg.sv
// Constants and types of the flash bus operation control block
// Functional notes
// - Chip select, output enable, address valid low, write high: drive read data.
// - Write exists with select and write low, enable high; latch at write rise.
// - Write cycles are asynchronous and never look at the burst clock.
// - Chip select high means standby with data outputs floating.
// - Deselecting the chip never stops a running program or erase.
// - Reset pin low disables the block and floats data and wait.
// - After reset: read array mode, status 80h, asynchronous page reads.
// - Reset pin during program or erase aborts that operation.
// - Identifier and query data sit at offsets from the partition base.
// - Status mode returns the addressed partition's status, never its array.
// - Identifier, query and status reads are single cycles, wait asserted; synchronous ones still burst and step the address.
// - Burst reads step the address per clock edge: 4, 8, 16 or endless.
// - Upper address bits select the partition of a read.
// - Asynchronous mode: latch open while address valid low, holds on rise.
// - Synchronous mode: latch on address valid rise or first clock edge.
// - Stopped clock with enable high suspends a burst and keeps its state.
// - Enable low plus clock restart resumes the burst at the held word.
// - Wait output is gated by chip select and reset pin, driven during suspend.
// - Wait carries data-valid only in synchronous array reads.
// - Only one partition may program or erase at a time.
// - Command FFh puts the addressed partition into read array mode.
// - Command 70h, or a program or erase, puts it in status mode.
package fboc_pkg;
    // ********************************
    // Widths and command codes
    // ********************************
    localparam int DATA_W = 16;
    localparam int ADDR_W = 22;
    localparam int PART_OFS_W = 18; // One 4-Mbit partition of words
    localparam int LATENCY_DEF = 2;
    localparam int FIFO_DEPTH_DEF = 16;
    localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
    localparam logic [7:0] CMD_READ_STATUS = 8'h70;
    localparam logic [7:0] CMD_READ_IDENT = 8'h90;
    localparam logic [7:0] CMD_READ_QUERY = 8'h98;
    localparam logic [7:0] CMD_PROG_SETUP = 8'h40;
    localparam logic [7:0] CMD_PROG_ALT = 8'h10;
    localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
    localparam logic [7:0] CMD_CONFIRM = 8'hD0;
    localparam logic [7:0] CMD_CFG_SETUP = 8'h60;
    localparam logic [7:0] CMD_CFG_CONFIRM = 8'h03;
    localparam logic [15:0] STATUS_READY = 16'h0080;
    localparam logic [15:0] STATUS_BUSY = 16'h0000;
    localparam int CFG_SYNC_BIT = 15;
    localparam int CFG_LEN_LSB = 0;
    localparam logic [3:0] MASK_4 = 4'h3;
    localparam logic [3:0] MASK_8 = 4'h7;
    localparam logic [3:0] MASK_16 = 4'hF;
    // ********************************
    // Types
    // ********************************
    typedef logic [1:0] fboc_mode_t;
    localparam fboc_mode_t MODE_ARRAY = 2'h0;
    localparam fboc_mode_t MODE_IDENT = 2'h1;
    localparam fboc_mode_t MODE_QUERY = 2'h2;
    localparam fboc_mode_t MODE_STATUS = 2'h3;
    localparam logic [1:0] LEN_4 = 2'h0;
    localparam logic [1:0] LEN_8 = 2'h1;
    localparam logic [1:0] LEN_16 = 2'h2;
    typedef struct packed {
        logic cs_n;
        logic oe_n;
        logic we_n;
        logic adv_n;
        logic rst_n;
        logic bclk;
    } fboc_pins_s;
    localparam fboc_pins_s PINS_IDLE = 6'h3F;
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } fboc_cmd_s;
    typedef struct packed {
        logic sync;
        logic [1:0] len;
    } fboc_cfg_s;
    localparam fboc_cfg_s CFG_RST = 3'h0; // Asynchronous page reads
    typedef enum logic [3:0] {
        C_IDLE = 4'h1, C_PROG = 4'h2, C_ERASE = 4'h4, C_CFG = 4'h8
    } fboc_cst_e;
    typedef enum logic [2:0] {
        B_IDLE = 3'h1, B_LAT = 3'h2, B_DATA = 3'h4
    } fboc_bst_e;
endpackage : fboc_pkg

// >>> fboc_top.sv
// Command FIFO and bus operation control of the partitioned flash
`timescale 1ns/10ps

// ********************************
// Write command FIFO
// ********************************
module fboc_fifo #(
    parameter int W = 8,
    parameter int DEPTH = 16
) (
    input logic clk_in, // Clock
    input logic rst_in, // Synchronous reset
    input logic clr_in, // Flush
    input logic in_vld_in, // Write side valid
    output logic in_rdy_out, // Write side ready
    input logic [W-1:0] in_data_in, // Write data
    output logic out_vld_out, // Read side valid
    input logic out_rdy_in, // Read side ready
    output logic [W-1:0] out_data_out // Read data
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] mem_r [DEPTH];
    logic [AW:0] wp_r;
    logic [AW:0] rp_r;
    wire full = (wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]);
    wire push = in_vld_in && !full;
    wire pop = out_vld_out && out_rdy_in;
    // Depth must be a power of two
    if (DEPTH < 2 || (2 ** AW) != DEPTH) begin : g_bad_depth
        $error("fifo depth must be a power of two");
    end
    // Flags and read port
    assign in_rdy_out = !full;
    assign out_vld_out = wp_r != rp_r;
    assign out_data_out = mem_r[rp_r[AW-1:0]];
    // Pointers
    always_ff @(posedge clk_in) begin
        if (rst_in || clr_in) begin
            wp_r <= '0;
            rp_r <= '0;
        end else begin
            if (push) begin
                wp_r <= wp_r + 1'h1;
            end
            if (pop) begin
                rp_r <= rp_r + 1'h1;
            end
        end
    end
    // Storage
    always_ff @(posedge clk_in) begin
        if (push) begin
            mem_r[wp_r[AW-1:0]] <= in_data_in;
        end
    end
endmodule : fboc_fifo

// ********************************
// Bus operation control
// ********************************
module fboc_top #(
    parameter int LATENCY = fboc_pkg::LATENCY_DEF,
    parameter int FIFO_DEPTH = fboc_pkg::FIFO_DEPTH_DEF
) (
    input logic CLK_IN, // 100 MHz clock
    input logic RESET_IN, // Synchronous reset
    input logic CS_N_IN, // Chip select pin
    input logic OE_N_IN, // Output enable pin
    input logic WE_N_IN, // Write strobe pin
    input logic ADDRESS_VALID_N_IN, // Address valid pin
    input logic RST_N_IN, // Reset pin
    input logic BCLK_IN, // Burst clock pin
    input logic [fboc_pkg::ADDR_W-1:0] ADDR_IN, // Address pins
    input logic [fboc_pkg::DATA_W-1:0] DQ_IN, // Data pins in
    output logic [fboc_pkg::DATA_W-1:0] DQ_OUT, // Data pins out
    output logic DQ_OE_OUT, // Data pins drive
    output logic WAIT_OUT, // Wait, high = not valid
    output logic WAIT_OE_OUT, // Wait drive
    output logic [fboc_pkg::ADDR_W-1:0] ARR_ADDR_OUT, // Array address
    output fboc_pkg::fboc_mode_t ARR_SPACE_OUT, // Array or info space
    output logic ARR_RD_OUT, // Array access
    input logic [fboc_pkg::DATA_W-1:0] ARR_DATA_IN, // Array data
    output logic PE_START_OUT, // Start program or erase
    output logic PE_ERASE_OUT, // Erase, not program
    output logic [fboc_pkg::ADDR_W-1:0] PE_ADDR_OUT, // Target address
    output logic [fboc_pkg::DATA_W-1:0] PE_DATA_OUT, // Program data
    input logic PE_READY_IN, // Engine takes a start
    input logic PE_DONE_IN, // Engine finished
    output logic PE_ABORT_OUT, // Abort pulse
    output logic WR_FULL_OUT // Write FIFO full
);
    localparam int AW = fboc_pkg::ADDR_W;
    localparam int PW = AW - fboc_pkg::PART_OFS_W;
    localparam int NPART = 2 ** PW;
    localparam int CW = $bits(fboc_pkg::fboc_cmd_s);
    // Latency counter is four bits wide
    if (LATENCY < 1 || LATENCY > 15) begin : g_bad_lat
        $error("latency out of range");
    end
    // Partition number from the upper address bits
    function automatic logic [PW-1:0] part_of(input logic [AW-1:0] a);
        return a[AW-1 -: PW];
    endfunction : part_of
    // Next address of a wrapping burst
    function automatic logic [AW-1:0] burst_next(
        input logic [AW-1:0] a, input logic [1:0] len);
        logic [AW-1:0] m;
        m = '1;
        if (len == fboc_pkg::LEN_4) begin
            m = AW'(fboc_pkg::MASK_4);
        end else if (len == fboc_pkg::LEN_8) begin
            m = AW'(fboc_pkg::MASK_8);
        end else if (len == fboc_pkg::LEN_16) begin
            m = AW'(fboc_pkg::MASK_16);
        end
        return (a & ~m) | ((a + 1'h1) & m);
    endfunction : burst_next
    // ********************************
    // Pin synchronisers
    // ********************************
    fboc_pkg::fboc_pins_s p1_r, p2_r, p3_r;
    logic [AW-1:0] a1_r, a2_r, a3_r;
    logic [15:0] d1_r, d2_r, d3_r;
    fboc_pkg::fboc_pins_s pin_raw;
    assign pin_raw = {CS_N_IN, OE_N_IN, WE_N_IN, ADDRESS_VALID_N_IN,
        RST_N_IN, BCLK_IN};
    // Two stages, third for edges
    always_ff @(posedge CLK_IN) begin
        if (RESET_IN) begin
            p1_r <= fboc_pkg::PINS_IDLE;
            p2_r <= fboc_pkg::PINS_IDLE;
            p3_r <= fboc_pkg::PINS_IDLE;
        end else begin
            p1_r <= pin_raw;
            p2_r <= p1_r;
            p3_r <= p2_r;
        end
    end
    // Address and data pins
    always_ff @(posedge CLK_IN) begin
        a1_r <= ADDR_IN;
        a2_r <= a1_r;
        a3_r <= a2_r;
        d1_r <= DQ_IN;
        d2_r <= d1_r;
        d3_r <= d2_r;
    end
    // ********************************
    // Bus decode
    // ********************************
    wire prst = !p2_r.rst_n;
    wire cs = !p2_r.cs_n && !prst;
    wire rd_cyc = cs && !p2_r.oe_n && p2_r.we_n;
    wire adv_low = !p2_r.adv_n;
    wire adv_rise = !p3_r.adv_n && p2_r.adv_n;
    wire adv_fall = p3_r.adv_n && !p2_r.adv_n;
    wire bclk_edge = p2_r.bclk && !p3_r.bclk;
    // Write strobe rise ends a write; burst clock not involved
    wire wr_rise = !p3_r.cs_n && p3_r.oe_n && !p3_r.we_n && p2_r.we_n
        && !prst;

    // ********************************
    // Command path
    // ********************************
    fboc_pkg::fboc_cmd_s fin, c;
    logic fifo_rdy, fifo_vld, pop_rdy;
    logic [CW-1:0] fifo_q;
    fboc_pkg::fboc_cst_e st_r, st_nxt;
    fboc_pkg::fboc_cfg_s cfg_r, cfg_nxt;
    logic busy_r, busy_nxt;
    logic [PW-1:0] busy_part_r;
    logic [NPART-1:0][1:0] mode_vec;
    assign fin = {a3_r, d3_r};
    assign c = fifo_q;
    fboc_fifo #(
        .W(CW),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_in(CLK_IN),
        .rst_in(RESET_IN),
        .clr_in(prst),
        .in_vld_in(wr_rise),
        .in_rdy_out(fifo_rdy),
        .in_data_in(fin),
        .out_vld_out(fifo_vld),
        .out_rdy_in(pop_rdy),
        .out_data_out(fifo_q)
    );
    // Command decode and pop
    wire [7:0] code = c.data[7:0];
    wire [PW-1:0] cpart = part_of(c.addr);
    wire idle = st_r == fboc_pkg::C_IDLE;
    wire is_conf = code == fboc_pkg::CMD_CONFIRM;
    wire needs_pe = st_r == fboc_pkg::C_PROG
        || (st_r == fboc_pkg::C_ERASE && is_conf);
    wire starts = needs_pe && !busy_r;
    assign pop_rdy = !prst && !(starts && !PE_READY_IN);
    wire pop = fifo_vld && pop_rdy;
    wire rd_code = code == fboc_pkg::CMD_READ_ARRAY
        || code == fboc_pkg::CMD_READ_STATUS
        || code == fboc_pkg::CMD_READ_IDENT
        || code == fboc_pkg::CMD_READ_QUERY;
    wire set_mode = pop && ((idle && rd_code)
        || st_r == fboc_pkg::C_PROG || st_r == fboc_pkg::C_ERASE);
    // New read mode of the commanded partition
    fboc_pkg::fboc_mode_t new_mode;
    assign new_mode = !idle ? fboc_pkg::MODE_STATUS :
        code == fboc_pkg::CMD_READ_ARRAY ? fboc_pkg::MODE_ARRAY :
        code == fboc_pkg::CMD_READ_STATUS ? fboc_pkg::MODE_STATUS :
        code == fboc_pkg::CMD_READ_IDENT ? fboc_pkg::MODE_IDENT :
        fboc_pkg::MODE_QUERY;
    // Setup sequence tracking
    assign st_nxt = !pop ? st_r :
        !idle ? fboc_pkg::C_IDLE :
        (code == fboc_pkg::CMD_PROG_SETUP
            || code == fboc_pkg::CMD_PROG_ALT) ? fboc_pkg::C_PROG :
        code == fboc_pkg::CMD_ERASE_SETUP ? fboc_pkg::C_ERASE :
        code == fboc_pkg::CMD_CFG_SETUP ? fboc_pkg::C_CFG :
        fboc_pkg::C_IDLE;
    wire cfg_wr = pop && st_r == fboc_pkg::C_CFG
        && code == fboc_pkg::CMD_CFG_CONFIRM;
    assign cfg_nxt = cfg_wr ? {c.addr[fboc_pkg::CFG_SYNC_BIT],
        c.addr[fboc_pkg::CFG_LEN_LSB +: 2]} : cfg_r;
    // Deselect has no say; only done or reset pin end an operation
    assign busy_nxt = (pop && starts) ? 1'h1 :
        PE_DONE_IN ? 1'h0 : busy_r;
    // Sequencer, configuration and engine hand-off
    always_ff @(posedge CLK_IN) begin
        if (RESET_IN || prst) begin
            st_r <= fboc_pkg::C_IDLE;
            cfg_r <= fboc_pkg::CFG_RST;
            busy_r <= 1'h0;
            PE_START_OUT <= 1'h0;
        end else begin
            st_r <= st_nxt;
            cfg_r <= cfg_nxt;
            busy_r <= busy_nxt;
            PE_START_OUT <= pop && starts;
        end
    end

    // Engine request fields and abort
    always_ff @(posedge CLK_IN) begin
        if (RESET_IN) begin
            busy_part_r <= '0;
            PE_ERASE_OUT <= 1'h0;
            PE_ADDR_OUT <= '0;
            PE_DATA_OUT <= '0;
            PE_ABORT_OUT <= 1'h0;
            WR_FULL_OUT <= 1'h0;
        end else begin
            if (pop && starts) begin
                busy_part_r <= cpart;
                PE_ERASE_OUT <= st_r == fboc_pkg::C_ERASE;
                PE_ADDR_OUT <= c.addr;
                PE_DATA_OUT <= c.data;
            end
            PE_ABORT_OUT <= prst && busy_r;
            WR_FULL_OUT <= !fifo_rdy;
        end
    end

    // Per-partition read mode
    for (genvar i = 0; i < NPART; i++) begin : g_part
        fboc_pkg::fboc_mode_t mode_r;
        assign mode_vec[i] = mode_r;
        always_ff @(posedge CLK_IN) begin
            if (RESET_IN || prst) begin
                mode_r <= fboc_pkg::MODE_ARRAY;
            end else if (set_mode && cpart == PW'(i)) begin
                mode_r <= new_mode;
            end
        end
    end

    // ********************************
    // Read path
    // ********************************
    fboc_pkg::fboc_bst_e bs_r, bs_nxt;
    logic [3:0] lat_r, lat_nxt;
    logic [AW-1:0] rd_addr_r, rd_addr_nxt;
    wire [PW-1:0] rpart = part_of(rd_addr_r);
    wire [1:0] rmode = mode_vec[rpart];
    wire in_lat = bs_r == fboc_pkg::B_LAT;
    wire in_data = bs_r == fboc_pkg::B_DATA;
    // First of address valid rise or clock edge with it low
    wire cap = cfg_r.sync && cs && (bs_r == fboc_pkg::B_IDLE || adv_fall)
        && ((adv_low && bclk_edge) || adv_rise);

    // Burst state: no clock edge means a held, suspended burst
    assign bs_nxt = (!cs || !cfg_r.sync) ? fboc_pkg::B_IDLE :
        cap ? fboc_pkg::B_LAT :
        adv_fall ? fboc_pkg::B_IDLE :
        (in_lat && bclk_edge && lat_r == 4'h0) ? fboc_pkg::B_DATA :
        bs_r;
    assign lat_nxt = cap ? 4'(LATENCY - 1) :
        (in_lat && bclk_edge && lat_r != 4'h0) ? lat_r - 4'h1 : lat_r;

    // Address latch and burst sequencing
    assign rd_addr_nxt = !cfg_r.sync ?
        ((cs && adv_low) ? a2_r : rd_addr_r) :
        cap ? (adv_rise ? a3_r : a2_r) :
        (in_data && bclk_edge) ?
            burst_next(rd_addr_r, cfg_r.len) :
        rd_addr_r;

    // Burst registers
    always_ff @(posedge CLK_IN) begin
        if (RESET_IN) begin
            bs_r <= fboc_pkg::B_IDLE;
            lat_r <= 4'h0;
            rd_addr_r <= '0;
        end else begin
            bs_r <= bs_nxt;
            lat_r <= lat_nxt;
            rd_addr_r <= rd_addr_nxt;
        end
    end
    assign ARR_ADDR_OUT = rd_addr_r;

    // Output selection
    wire own_busy = busy_r && busy_part_r == rpart;
    wire is_stat = rmode == fboc_pkg::MODE_STATUS;
    wire [15:0] stat = own_busy ? fboc_pkg::STATUS_BUSY :
        fboc_pkg::STATUS_READY;
    wire [15:0] dq_nxt = is_stat ? stat : ARR_DATA_IN;
    wire drive = rd_cyc && (cfg_r.sync || adv_low);
    // Wait is data-valid only in synchronous array bursts
    wire wait_nxt = !(cfg_r.sync && in_data
        && rmode == fboc_pkg::MODE_ARRAY);

    // Pin-facing registers
    always_ff @(posedge CLK_IN) begin
        if (RESET_IN) begin
            DQ_OUT <= '0;
            DQ_OE_OUT <= 1'h0;
            WAIT_OUT <= 1'h1;
            WAIT_OE_OUT <= 1'h0;
            ARR_SPACE_OUT <= fboc_pkg::MODE_ARRAY;
            ARR_RD_OUT <= 1'h0;
        end else begin
            DQ_OUT <= dq_nxt;
            DQ_OE_OUT <= drive;
            WAIT_OUT <= wait_nxt;
            WAIT_OE_OUT <= cs;
            ARR_SPACE_OUT <= rmode;
            ARR_RD_OUT <= rd_cyc && !is_stat;
        end
    end

    // ********************************
    // Assertions
    // ********************************
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (RESET_IN);

    sequence s_wr_low;
        !p2_r.cs_n && p2_r.oe_n && !p2_r.we_n && p2_r.rst_n;
    endsequence
    sequence s_wr_strobe;
        s_wr_low ##1 (p2_r.we_n && p2_r.rst_n);
    endsequence

    a_write_capture: assert property (
        s_wr_strobe |-> wr_rise && fin.addr == $past(a2_r))
        else $error("write strobe rise not captured");
    a_standby_float: assert property (
        p2_r.cs_n |=> !DQ_OE_OUT && !WAIT_OE_OUT)
        else $error("outputs driven in standby");
    a_reset_float: assert property (
        !p2_r.rst_n |=> !DQ_OE_OUT && !WAIT_OE_OUT && !ARR_RD_OUT)
        else $error("outputs driven in reset");
    a_reset_default: assert property (
        !p2_r.rst_n |=> !cfg_r.sync && g_part[0].mode_r == 2'h0)
        else $error("reset defaults not loaded");
    a_abort_op: assert property (
        (busy_r && !p2_r.rst_n) |=> PE_ABORT_OUT && !busy_r)
        else $error("operation not aborted");
    a_busy_hold: assert property (
        (busy_r && p2_r.cs_n && p2_r.rst_n && !PE_DONE_IN) |=> busy_r)
        else $error("operation lost on deselect");
    a_one_engine: assert property (
        (busy_r && !PE_DONE_IN) |=> !PE_START_OUT)
        else $error("second program or erase started");
    a_read_drive: assert property (
        (!p2_r.cs_n && !p2_r.oe_n && !p2_r.adv_n && p2_r.we_n
            && p2_r.rst_n) |=> DQ_OE_OUT)
        else $error("read data not driven");
    a_wait_async: assert property (
        (!cfg_r.sync) [*2] |-> WAIT_OUT)
        else $error("wait released outside burst");
    a_sync_capture: assert property (
        cap |=> in_lat && rd_addr_r == $past(adv_rise ? a3_r : a2_r))
        else $error("burst address not captured");
    a_suspend_hold: assert property (
        (in_data && !bclk_edge && cs && !adv_fall) |=>
            $stable(rd_addr_r) && in_data)
        else $error("suspended burst moved");
endmodule : fboc_top

// >>> fboc_host.sv
// Host bus model that drives the flash control pins
`timescale 1ns/10ps
// ****************
// Host pin driver
// ****************
module fboc_host (
    input wire logic clk_in, // Clock
    output fboc_pkg::fboc_pins_s pins_out, // Control pins
    output logic [fboc_pkg::ADDR_W-1:0] addr_out, // Address pins
    output logic [fboc_pkg::DATA_W-1:0] dq_out // Data pins
);
    // Idle bus, burst clock parked high for asynchronous use
    initial begin
        pins_out = fboc_pkg::PINS_IDLE;
        addr_out = 22'h000000;
        dq_out = 16'h0000;
    end
    // Wait n edges, then step just past the edge
    task automatic hold(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask : hold
    // One write cycle, data taken at the strobe rise
    task automatic wr(input logic [21:0] a, input logic [15:0] d);
        addr_out = a;
        dq_out = d;
        pins_out.cs_n = 1'b0;
        pins_out.we_n = 1'b0;
        hold(4);
        pins_out.we_n = 1'b1;
        hold(4);
        pins_out.cs_n = 1'b1;
        dq_out = ~d; // Released bus shows no stale value
        hold(6);
    endtask : wr
    // Opens a read; write strobe and reset pin stay high
    task automatic rd_open(input logic [21:0] a, input logic cs_n,
                           input logic oe_n);
        addr_out = a;
        pins_out.cs_n = cs_n;
        pins_out.adv_n = 1'b0;
        pins_out.oe_n = oe_n;
        hold(8);
    endtask : rd_open
    // Ends any cycle
    task automatic close();
        pins_out = fboc_pkg::PINS_IDLE;
        hold(6);
    endtask : close
    // One burst clock period, clock parked high again after it
    task automatic tick();
        pins_out.bclk = 1'b0;
        hold(3);
        pins_out.bclk = 1'b1;
        hold(5);
    endtask : tick
    // Output enable alone, burst clock left stopped
    task automatic oe_set(input logic oe_n);
        pins_out.oe_n = oe_n;
        hold(6);
    endtask : oe_set
    // Reset pin pulse followed by the wake-up wait
    task automatic pin_reset();
        pins_out.rst_n = 1'b0;
        hold(4);
        pins_out.rst_n = 1'b1;
        hold(8);
    endtask : pin_reset
endmodule : fboc_host

// >>> tb_top.sv
// Self-checking bench for the flash bus operation control
`timescale 1ns/10ps
// ****************
// Bench top
// ****************
module tb_top;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic pe_done = 1'b0;
    fboc_pkg::fboc_pins_s pins;
    fboc_pkg::fboc_mode_t space;
    logic [fboc_pkg::ADDR_W-1:0] addr, arr_addr, pe_addr;
    logic [15:0] dq_in, dq_out, arr_data, pe_data;
    logic dq_oe, wt, wt_oe, arr_rd, pe_start, pe_erase, pe_abort, wr_full;
    int miscompares = 0;
    int n_compared = 0;
    int n_start = 0;
    int n_abort = 0;
    logic [7:0] codes [2] = '{8'h90, 8'h98};
    // Clock
    always #5 clk = ~clk;
    // Array model answers at once, space folded into the data
    assign arr_data = arr_addr[15:0] ^ {14'h0000, space};
    // Counts engine start and abort pulses
    always @(posedge clk) begin
        if (pe_start === 1'b1) n_start++;
        if (pe_abort === 1'b1) n_abort++;
    end
    fboc_host i_fboc_host (.clk_in(clk), .pins_out(pins), .addr_out(addr),
        .dq_out(dq_in));
    fboc_top i_fboc_top (.CLK_IN(clk), .RESET_IN(rst), .CS_N_IN(pins.cs_n),
        .OE_N_IN(pins.oe_n), .WE_N_IN(pins.we_n),
        .ADDRESS_VALID_N_IN(pins.adv_n), .RST_N_IN(pins.rst_n),
        .BCLK_IN(pins.bclk), .ADDR_IN(addr), .DQ_IN(dq_in), .DQ_OUT(dq_out),
        .DQ_OE_OUT(dq_oe), .WAIT_OUT(wt), .WAIT_OE_OUT(wt_oe),
        .ARR_ADDR_OUT(arr_addr), .ARR_SPACE_OUT(space), .ARR_RD_OUT(arr_rd),
        .ARR_DATA_IN(arr_data), .PE_START_OUT(pe_start),
        .PE_ERASE_OUT(pe_erase), .PE_ADDR_OUT(pe_addr), .PE_DATA_OUT(pe_data),
        .PE_READY_IN(1'b1), .PE_DONE_IN(pe_done), .PE_ABORT_OUT(pe_abort),
        .WR_FULL_OUT(wr_full));
    // Compares one value
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // Full read: data, drive and wait flags, then release
    task automatic rd(input logic [21:0] a, input logic [15:0] exp);
        i_fboc_host.rd_open(a, 1'b0, 1'b0);
        check(dq_out, exp);
        check({13'h0000, dq_oe, wt, wt_oe}, 16'h0007);
        i_fboc_host.close();
        check({14'h0000, dq_oe, wt_oe}, 16'h0000);
    endtask : rd
    // Outputs quiet after reset, then a default array read
    task automatic sc_array();
        check({14'h0000, dq_oe, wt_oe}, 16'h0000);
        rd(22'h0C1234, 16'h1234);
    endtask : sc_array
    // Standby and output disable keep the data bus released
    task automatic sc_idle();
        i_fboc_host.rd_open(22'h000010, 1'b1, 1'b0);
        check({14'h0000, dq_oe, wt_oe}, 16'h0000);
        i_fboc_host.rd_open(22'h000010, 1'b0, 1'b1);
        check({13'h0000, dq_oe, arr_rd, wt_oe}, 16'h0001);
        i_fboc_host.close();
    endtask : sc_idle
    // Read modes per partition, chosen by the upper address bits
    task automatic sc_modes();
        i_fboc_host.wr(22'h0C0000, 16'h0070);
        rd(22'h0C0005, 16'h0080);
        rd(22'h100005, 16'h0005);
        for (int i = 0; i < 2; i++) begin
            i_fboc_host.wr(22'h080000, {8'h00, codes[i]});
            rd(22'h080003, 16'h0003 ^ 16'(i + 1));
        end
        i_fboc_host.wr(22'h080000, 16'h00FF);
        i_fboc_host.wr(22'h0C0000, 16'h00FF);
        rd(22'h0C0005, 16'h0005);
        rd(22'h080003, 16'h0003);
    endtask : sc_modes
    // Program, refused second program, erase aborted by the reset pin
    task automatic sc_program();
        i_fboc_host.wr(22'h140010, 16'h0040);
        i_fboc_host.wr(22'h140010, 16'hBEEF);
        check(16'(n_start), 16'h0001);
        check(pe_data, 16'hBEEF);
        check({pe_addr[21:18], pe_addr[11:0]}, 16'h5010);
        check({15'h0000, pe_erase}, 16'h0000);
        check({15'h0000, wr_full}, 16'h0000);
        rd(22'h140010, 16'h0000);
        i_fboc_host.wr(22'h180000, 16'h0040);
        i_fboc_host.wr(22'h180000, 16'h1111);
        check(16'(n_start), 16'h0001);
        check(16'(n_abort), 16'h0000);
        pe_done = 1'b1;
        i_fboc_host.hold(1);
        pe_done = 1'b0;
        rd(22'h140010, 16'h0080);
        i_fboc_host.wr(22'h1C0000, 16'h0020);
        i_fboc_host.wr(22'h1C0000, 16'h00D0);
        check({15'h0000, pe_erase}, 16'h0001);
        i_fboc_host.pin_reset();
        check(16'(n_abort), 16'h0001);
        rd(22'h1C0007, 16'h0007);
    endtask : sc_program
    // Synchronous burst of four: latency, wrap, suspend and resume
    task automatic sc_burst();
        i_fboc_host.wr(22'h008000, 16'h0060);
        i_fboc_host.wr(22'h008000, 16'h0003);
        i_fboc_host.rd_open(22'h100006, 1'b0, 1'b0);
        i_fboc_host.tick();
        i_fboc_host.tick();
        check({13'h0000, dq_oe, wt, wt_oe}, 16'h0007);
        i_fboc_host.tick();
        check(dq_out, 16'h0006);
        check({13'h0000, dq_oe, wt, wt_oe}, 16'h0005);
        i_fboc_host.tick();
        check(dq_out, 16'h0007);
        i_fboc_host.tick();
        check(dq_out, 16'h0004);
        i_fboc_host.oe_set(1'b1);
        check(arr_addr[15:0], 16'h0004);
        check({14'h0000, dq_oe, wt_oe}, 16'h0001);
        i_fboc_host.oe_set(1'b0);
        i_fboc_host.tick();
        check(dq_out, 16'h0005);
        i_fboc_host.close();
    endtask : sc_burst
    // Prints the counts and the verdict
    task automatic tally_and_finish();
        $display("Compared %0d, mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : tally_and_finish
    // Cuts a hang short
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        tally_and_finish();
    end
    // Main sequence
    initial begin
        repeat (5) @(posedge clk);
        #1;
        rst = 1'b0;
        i_fboc_host.hold(3);
        sc_array();
        sc_idle();
        sc_modes();
        sc_program();
        sc_burst();
        tally_and_finish();
    end
endmodule : tb_top
